//--- design/iaalu_pkg.sv
// Package for the immediate arithmetic datapath: opcodes, timing, carriers, state.
// Assumes one 250 MHz clock and a synchronous active-low reset in the user.
package iaalu_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // First-byte opcodes
  localparam logic [7:0] OPC_BCD_ADD = 8'hEC;  // bcd_add_immediate
  localparam logic [7:0] OPC_BIN_ADD = 8'hF4;  // binary_add_immediate
  localparam logic [7:0] OPC_CMP_ADD = 8'hFC;  // complement_add_immediate

  //////////////////////////////////////////////////////////////////////////////
  // Timing: microcycle length and execution times in microcycles
  localparam int         UCYC_CLKS   = 4;      // Clock cycles per microcycle
  localparam int         UC_BCD      = 15;     // Decimal add duration
  localparam int         UC_BIN      = 11;     // Binary add duration
  localparam int         UC_CMP      = 12;     // Complement add duration
  localparam logic [3:0] UCYC_LAST   = 4'(UCYC_CLKS - 1);
  localparam logic [3:0] UC_BCD_LAST = 4'(UC_BCD - 1);
  localparam logic [3:0] UC_BIN_LAST = 4'(UC_BIN - 1);
  localparam logic [3:0] UC_CMP_LAST = 4'(UC_CMP - 1);

  //////////////////////////////////////////////////////////////////////////////
  // Decimal digit limits
  localparam logic [4:0] BCD_DIGIT_MAX = 5'h09;  // Largest decimal digit
  localparam logic [4:0] BCD_ADJUST    = 5'h06;  // Skip of six unused codes

  //////////////////////////////////////////////////////////////////////////////
  // Types
  typedef enum logic [1:0] {IA_IDLE, IA_WAIT_DATA, IA_EXEC} iaalu_state_t;
  typedef enum logic [1:0] {IA_OP_BCD, IA_OP_BIN, IA_OP_CMP} iaalu_op_t;

  // Program byte stream
  typedef struct packed {
    logic       valid;  // Byte present this cycle
    logic [7:0] value;  // Opcode or immediate data
  } iaalu_byte_t;

  // Direct load of operand register and flags
  typedef struct packed {
    logic       acc_wr;   // Load main operand register
    logic [7:0] acc_val;  // Value to load
    logic       flag_wr;  // Load both flags
    logic       cy_val;   // Carry/link value
    logic       ov_val;   // Sign wrap value
  } iaalu_load_t;

  // Whole state of the datapath
  typedef struct packed {
    iaalu_state_t state;    // Sequencer state
    iaalu_op_t    op;       // Decoded operation
    logic [7:0]   data;     // Captured immediate byte
    logic [7:0]   acc;      // Main operand register
    logic         cy;       // Carry/link flag
    logic         ov;       // Sign wrap flag
    logic [3:0]   div;      // Clocks within microcycle
    logic [3:0]   ucnt;     // Microcycles elapsed
    logic         busy;     // Executing
    logic         ready;    // Program byte accepted
    logic         done;     // Result written pulse
    logic         unknown;  // Unrecognised opcode pulse
  } iaalu_regs_t;

  localparam iaalu_regs_t REGS_RST = '{state: IA_IDLE, op: IA_OP_BCD, data: 8'h00, acc: 8'h00,
                                       cy: 1'b0, ov: 1'b0, div: 4'h0, ucnt: 4'h0, busy: 1'b0,
                                       ready: 1'b1, done: 1'b0, unknown: 1'b0};

endpackage

//--- design/iaalu_core.sv
// Immediate arithmetic datapath: decimal, binary and complement add with carry.
// Assumes program bytes arrive in order, synchronous to ref_clk.
// Contract
// - Decimal add of packed BCD, 15 microcycles
// - Decimal carry from upper digit; overflow kept
// - Binary add with carry, 11 microcycles
// - Binary carry from bit 7
// - Binary overflow when result sign differs both
// - Add inverted data with carry, 12 microcycles
// - Complement add carry from bit 7
// - Complement overflow: sign matches data, not register
// - Opcodes EC, F4, FC decode the three
// - Carry set makes complement add a subtract
`timescale 1ns/1ps
`default_nettype none

module iaalu_core (
  // Clock and reset
  input  wire logic               ref_clk,
  input  wire logic               rst_b,
  // Program byte stream
  input  wire iaalu_pkg::iaalu_byte_t prog_byte,
  output logic                    prog_ready,
  // Direct loads
  input  wire iaalu_pkg::iaalu_load_t load,
  // Datapath state
  output logic [7:0]              main_operand_register,
  output logic                    carry_link_flag,
  output logic                    sign_wrap_flag,
  // Status
  output logic                    busy,
  output logic                    done,
  output logic                    opcode_unknown
);

  //////////////////////////////////////////////////////////////////////////////
  // State
  iaalu_pkg::iaalu_regs_t r_reg;   // Registered state
  iaalu_pkg::iaalu_regs_t r_next;  // Next state

  // Outputs straight from flops
  assign prog_ready            = r_reg.ready;
  assign main_operand_register = r_reg.acc;
  assign carry_link_flag       = r_reg.cy;
  assign sign_wrap_flag        = r_reg.ov;
  assign busy                  = r_reg.busy;
  assign done                  = r_reg.done;
  assign opcode_unknown        = r_reg.unknown;

  //////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    logic [4:0] lo;     // Low digit sum
    logic [4:0] hi;     // High digit sum
    logic       lo_c;   // Low digit decimal carry
    logic       hi_c;   // High digit decimal carry
    logic [7:0] opnd;   // Second addend
    logic [8:0] sum;    // Binary sum with carry out
    logic [3:0] last;   // Final microcycle index
    logic       tick;   // Microcycle boundary
    lo     = 5'h00;
    hi     = 5'h00;
    lo_c   = 1'b0;
    hi_c   = 1'b0;
    opnd   = 8'h00;
    sum    = 9'h000;
    last   = iaalu_pkg::UC_BCD_LAST;
    tick   = 1'b0;
    r_next = r_reg;
    r_next.done    = 1'b0;
    r_next.unknown = 1'b0;
    // Loads only outside execution
    if (r_reg.state != iaalu_pkg::IA_EXEC) begin
      if (load.acc_wr) begin
        r_next.acc = load.acc_val;
      end
      if (load.flag_wr) begin
        r_next.cy = load.cy_val;
        r_next.ov = load.ov_val;
      end
    end
    case (r_reg.state)
      // Wait for an opcode byte
      iaalu_pkg::IA_IDLE: begin
        if (prog_byte.valid) begin
          case (prog_byte.value)
            iaalu_pkg::OPC_BCD_ADD: begin
              r_next.op    = iaalu_pkg::IA_OP_BCD;
              r_next.state = iaalu_pkg::IA_WAIT_DATA;
            end
            iaalu_pkg::OPC_BIN_ADD: begin
              r_next.op    = iaalu_pkg::IA_OP_BIN;
              r_next.state = iaalu_pkg::IA_WAIT_DATA;
            end
            iaalu_pkg::OPC_CMP_ADD: begin
              r_next.op    = iaalu_pkg::IA_OP_CMP;
              r_next.state = iaalu_pkg::IA_WAIT_DATA;
            end
            default: begin
              r_next.unknown = 1'b1;  // Not ours: dropped
            end
          endcase
        end
      end
      // Next byte is the immediate operand
      iaalu_pkg::IA_WAIT_DATA: begin
        if (prog_byte.valid) begin
          r_next.data  = prog_byte.value;
          r_next.state = iaalu_pkg::IA_EXEC;
          r_next.div   = 4'h0;
          r_next.ucnt  = 4'h0;
          r_next.busy  = 1'b1;
          r_next.ready = 1'b0;
        end
      end
      // Count microcycles, then write back
      iaalu_pkg::IA_EXEC: begin
        tick = (r_reg.div == iaalu_pkg::UCYC_LAST);
        r_next.div = tick ? 4'h0 : r_reg.div + 4'h1;
        case (r_reg.op)
          iaalu_pkg::IA_OP_BIN: last = iaalu_pkg::UC_BIN_LAST;
          iaalu_pkg::IA_OP_CMP: last = iaalu_pkg::UC_CMP_LAST;
          default:              last = iaalu_pkg::UC_BCD_LAST;
        endcase
        // Decimal digits, low then high
        lo   = {1'b0, r_reg.acc[3:0]} + {1'b0, r_reg.data[3:0]} + {4'h0, r_reg.cy};
        lo_c = (lo > iaalu_pkg::BCD_DIGIT_MAX);
        if (lo_c) begin
          lo = lo + iaalu_pkg::BCD_ADJUST;
        end
        hi   = {1'b0, r_reg.acc[7:4]} + {1'b0, r_reg.data[7:4]} + {4'h0, lo_c};
        hi_c = (hi > iaalu_pkg::BCD_DIGIT_MAX);
        if (hi_c) begin
          hi = hi + iaalu_pkg::BCD_ADJUST;
        end
        // Binary sum, data inverted for complement add
        opnd = (r_reg.op == iaalu_pkg::IA_OP_CMP) ? ~r_reg.data : r_reg.data;
        sum  = {1'b0, r_reg.acc} + {1'b0, opnd} + {8'h00, r_reg.cy};
        if (tick) begin
          if (r_reg.ucnt == last) begin
            r_next.state = iaalu_pkg::IA_IDLE;
            r_next.busy  = 1'b0;
            r_next.ready = 1'b1;
            r_next.done  = 1'b1;
            case (r_reg.op)
              iaalu_pkg::IA_OP_BCD: begin
                r_next.acc = {hi[3:0], lo[3:0]};
                r_next.cy  = hi_c;
              end
              iaalu_pkg::IA_OP_BIN: begin
                r_next.acc = sum[7:0];
                r_next.cy  = sum[8];
                r_next.ov  = (sum[7] != r_reg.acc[7]) && (sum[7] != r_reg.data[7]);
              end
              default: begin
                r_next.acc = sum[7:0];
                r_next.cy  = sum[8];
                r_next.ov  = (sum[7] == r_reg.data[7]) && (sum[7] != r_reg.acc[7]);
              end
            endcase
          end else begin
            r_next.ucnt = r_reg.ucnt + 4'h1;
          end
        end
      end
      default: begin
        r_next = iaalu_pkg::REGS_RST;
      end
    endcase
  end

  //////////////////////////////////////////////////////////////////////////////
  // State register
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      r_reg <= iaalu_pkg::REGS_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions
  // Sampled rise of busy to sampled done: busy stands N*4 cycles, done follows its last one
  localparam int LAT_BCD = iaalu_pkg::UC_BCD * iaalu_pkg::UCYC_CLKS;
  localparam int LAT_BIN = iaalu_pkg::UC_BIN * iaalu_pkg::UCYC_CLKS;
  localparam int LAT_CMP = iaalu_pkg::UC_CMP * iaalu_pkg::UCYC_CLKS;

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);

  // Decimal value of the result matches decimal sum
  property p_bcd_value;
    done && r_reg.op == iaalu_pkg::IA_OP_BCD && r_reg.data[7:4] < 4'hA && r_reg.data[3:0] < 4'hA
      && $past(r_reg.acc[7:4]) < 4'hA && $past(r_reg.acc[3:0]) < 4'hA
      |-> (int'(r_reg.acc[7:4]) * 10 + int'(r_reg.acc[3:0]) + (r_reg.cy ? 100 : 0))
          == (int'($past(r_reg.acc[7:4])) * 10 + int'($past(r_reg.acc[3:0]))
              + int'(r_reg.data[7:4]) * 10 + int'(r_reg.data[3:0]) + ($past(r_reg.cy) ? 1 : 0));
  endproperty
  a_bcd_value: assert property (p_bcd_value) else $error("decimal add wrong");

  property p_bcd_time;
    $rose(r_reg.busy) && r_reg.op == iaalu_pkg::IA_OP_BCD |-> ##LAT_BCD (done && !r_reg.busy && $past(r_reg.busy));
  endproperty
  a_bcd_time: assert property (p_bcd_time) else $error("decimal add duration wrong");

  property p_bcd_ov;
    done && r_reg.op == iaalu_pkg::IA_OP_BCD |-> r_reg.ov == $past(r_reg.ov);
  endproperty
  a_bcd_ov: assert property (p_bcd_ov) else $error("decimal add changed overflow");

  property p_bin_sum;
    done && r_reg.op == iaalu_pkg::IA_OP_BIN
      |-> {r_reg.cy, r_reg.acc} == {1'b0, $past(r_reg.acc)} + {1'b0, r_reg.data} + {8'h00, $past(r_reg.cy)};
  endproperty
  a_bin_sum: assert property (p_bin_sum) else $error("binary sum or carry wrong");

  property p_bin_time;
    $rose(r_reg.busy) && r_reg.op == iaalu_pkg::IA_OP_BIN |-> ##LAT_BIN (done && $past(r_reg.busy));
  endproperty
  a_bin_time: assert property (p_bin_time) else $error("binary add duration wrong");

  property p_bin_ov;
    done && r_reg.op == iaalu_pkg::IA_OP_BIN
      |-> r_reg.ov == (r_reg.acc[7] != $past(r_reg.acc[7]) && r_reg.acc[7] != r_reg.data[7]);
  endproperty
  a_bin_ov: assert property (p_bin_ov) else $error("binary overflow wrong");

  property p_cmp_sum;
    done && r_reg.op == iaalu_pkg::IA_OP_CMP
      |-> {r_reg.cy, r_reg.acc} == {1'b0, $past(r_reg.acc)} + {1'b0, ~r_reg.data} + {8'h00, $past(r_reg.cy)};
  endproperty
  a_cmp_sum: assert property (p_cmp_sum) else $error("complement sum or carry wrong");

  property p_cmp_time;
    $rose(r_reg.busy) && r_reg.op == iaalu_pkg::IA_OP_CMP |-> ##LAT_CMP (done && $past(r_reg.busy));
  endproperty
  a_cmp_time: assert property (p_cmp_time) else $error("complement add duration wrong");

  property p_cmp_ov;
    done && r_reg.op == iaalu_pkg::IA_OP_CMP
      |-> r_reg.ov == (r_reg.acc[7] == r_reg.data[7] && r_reg.acc[7] != $past(r_reg.acc[7]));
  endproperty
  a_cmp_ov: assert property (p_cmp_ov) else $error("complement overflow wrong");

  property p_cmp_sub;
    done && r_reg.op == iaalu_pkg::IA_OP_CMP && $past(r_reg.cy) |-> r_reg.acc == $past(r_reg.acc) - r_reg.data;
  endproperty
  a_cmp_sub: assert property (p_cmp_sub) else $error("complement add is not a subtract");

  property p_decode;
    r_reg.state == iaalu_pkg::IA_IDLE && prog_byte.valid && prog_byte.value == iaalu_pkg::OPC_BIN_ADD
      |=> r_reg.state == iaalu_pkg::IA_WAIT_DATA && r_reg.op == iaalu_pkg::IA_OP_BIN && !opcode_unknown;
  endproperty
  a_decode: assert property (p_decode) else $error("binary opcode not decoded");

  property p_data_byte;
    r_reg.state == iaalu_pkg::IA_WAIT_DATA && prog_byte.valid
      |=> busy && !prog_ready && r_reg.data == $past(prog_byte.value);
  endproperty
  a_data_byte: assert property (p_data_byte) else $error("immediate byte not taken");

  c_bcd_done: cover property (done && r_reg.op == iaalu_pkg::IA_OP_BCD && r_reg.cy);
  c_bin_ov:   cover property (done && r_reg.op == iaalu_pkg::IA_OP_BIN && r_reg.ov);
  c_cmp_sub:  cover property (done && r_reg.op == iaalu_pkg::IA_OP_CMP && $past(r_reg.cy));
  c_unknown:  cover property (opcode_unknown);

endmodule  // iaalu_core

`default_nettype wire

//--- dv/test_immediate_arith_alu.sv
// Self-checking bench for the immediate arithmetic datapath.
// Assumes iaalu_pkg and iaalu_core are compiled first; no other models.
`timescale 1ns/1ps
`default_nettype none

`define CHK(act, exp, msg) begin check_count++; if ((act) !== (exp)) begin errors++; \
  $display("[ERR] %0t %s", $time, msg); end end

module test_immediate_arith_alu;

  ////////////////////////////////////////////////////////////////////////////////
  // Signals
  logic                   ref_clk;      // 250 MHz clock
  logic                   rst_b;        // Synchronous reset, active low
  iaalu_pkg::iaalu_byte_t prog_byte;    // Program byte stream
  iaalu_pkg::iaalu_load_t load;         // Direct loads
  logic                   prog_ready;   // Byte accepted
  logic [7:0]             acc;          // Main operand register
  logic                   cy;           // Carry/link flag
  logic                   ov;           // Sign wrap flag
  logic                   busy;         // Executing
  logic                   done;         // Result pulse
  logic                   unk;          // Unknown opcode pulse
  int                     errors;       // Mismatch count
  int                     check_count;  // Comparison count

  iaalu_core iaalu_core_inst (
    .ref_clk               (ref_clk),
    .rst_b                 (rst_b),
    .prog_byte             (prog_byte),
    .prog_ready            (prog_ready),
    .load                  (load),
    .main_operand_register (acc),
    .carry_link_flag       (cy),
    .sign_wrap_flag        (ov),
    .busy                  (busy),
    .done                  (done),
    .opcode_unknown        (unk)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Clock
  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  // Expected {carry, overflow, result}
  function automatic logic [9:0] model(input logic [7:0] opc, a, d, input logic c, o);
    logic [4:0] lo;
    logic [4:0] hi;
    logic [7:0] e;
    logic [8:0] s;
    if (opc == 8'hEC) begin
      lo = 5'(a[3:0]) + 5'(d[3:0]) + 5'(c);
      if (lo > 5'h09) lo = lo + 5'h06;
      hi = 5'(a[7:4]) + 5'(d[7:4]) + 5'(lo[4]);
      if (hi > 5'h09) hi = hi + 5'h06;
      return {hi[4], o, hi[3:0], lo[3:0]};
    end
    e = (opc == 8'hFC) ? ~d : d;
    s = 9'(a) + 9'(e) + 9'(c);
    if (opc == 8'hFC) return {s[8], s[7] == d[7] && s[7] != a[7], s[7:0]};
    return {s[8], a[7] == d[7] && s[7] != a[7], s[7:0]};
  endfunction

  // Clock edge, then drive delay
  task automatic tick();
    @(posedge ref_clk);
    #1;
  endtask

  // Load operand register and both flags
  task automatic set_state(input logic [7:0] a, input logic c, o);
    load = '{acc_wr: 1'b1, acc_val: a, flag_wr: 1'b1, cy_val: c, ov_val: o};
    tick();
    load = '0;
    `CHK({acc, cy, ov}, {a, c, o}, "load")
  endtask

  // Opcode then immediate byte on consecutive edges
  task automatic send(input logic [7:0] opc, d);
    prog_byte = '{valid: 1'b1, value: opc};
    tick();
    prog_byte.value = d;
    tick();
    prog_byte = '0;
  endtask

  // Wait for done and check duration and busy; pre counts edges already spent since the data byte
  task automatic wait_done(input int n, input int pre);
    int k;
    logic b2;
    k = 0;
    b2 = 1'b0;
    while (done !== 1'b1 && k < 200) begin
      tick();
      k++;
      if (k == 2) b2 = busy;
    end
    `CHK(k + pre, n * 4, "duration")
    `CHK({b2, busy, prog_ready}, 3'h5, "busy span")
  endtask

  // One full instruction with its expectation
  task automatic run_op(input logic [7:0] opc, a, d, input logic c, o, input int n);
    logic [9:0] x;
    x = model(opc, a, d, c, o);
    set_state(a, c, o);
    send(opc, d);
    wait_done(n, 0);
    `CHK({cy, ov, acc}, x, "result")
    tick();
    `CHK(done, 1'b0, "done pulse")
  endtask

  task automatic t_reset();
    `CHK({acc, cy, ov, busy, done, unk, prog_ready}, 14'h0001, "reset")
  endtask

  task automatic t_bcd();
    run_op(8'hEC, 8'h45, 8'h38, 1'b0, 1'b1, 15);
    run_op(8'hEC, 8'h99, 8'h01, 1'b0, 1'b0, 15);
    run_op(8'hEC, 8'h58, 8'h41, 1'b1, 1'b1, 15);
    run_op(8'hEC, 8'h09, 8'h00, 1'b1, 1'b0, 15);
  endtask

  task automatic t_bin();
    run_op(8'hF4, 8'h7F, 8'h01, 1'b0, 1'b0, 11);
    run_op(8'hF4, 8'hFF, 8'h01, 1'b0, 1'b1, 11);
    run_op(8'hF4, 8'h80, 8'h80, 1'b0, 1'b0, 11);
    run_op(8'hF4, 8'h01, 8'h02, 1'b1, 1'b1, 11);
  endtask

  task automatic t_cmp();
    run_op(8'hFC, 8'h05, 8'h03, 1'b1, 1'b0, 12);
    `CHK(acc, 8'h02, "subtract")
    run_op(8'hFC, 8'h03, 8'h05, 1'b1, 1'b1, 12);
    `CHK(acc, 8'hFE, "subtract")
    run_op(8'hFC, 8'h80, 8'h01, 1'b1, 1'b0, 12);
    run_op(8'hFC, 8'h7F, 8'hFF, 1'b1, 1'b0, 12);
    run_op(8'hFC, 8'h10, 8'h10, 1'b0, 1'b1, 12);
  endtask

  // Unrecognised opcode is dropped and flagged
  task automatic t_unknown();
    prog_byte = '{valid: 1'b1, value: 8'hC4};
    tick();
    prog_byte = '0;
    `CHK({unk, busy}, 2'h2, "unknown flag")
    tick();
    `CHK({unk, busy}, 2'h0, "unknown pulse")
    run_op(8'hF4, 8'h20, 8'h22, 1'b0, 1'b0, 11);
  endtask

  // Bytes and loads during execution are ignored
  task automatic t_busy();
    set_state(8'h10, 1'b0, 1'b0);
    send(8'hF4, 8'h20);
    tick();
    tick();
    `CHK(prog_ready, 1'b0, "ready low")
    load = '{acc_wr: 1'b1, acc_val: 8'h55, flag_wr: 1'b1, cy_val: 1'b1, ov_val: 1'b1};
    prog_byte = '{valid: 1'b1, value: 8'hEC};
    tick();
    load = '0;
    prog_byte = '0;
    wait_done(11, 3);
    `CHK({cy, ov, acc}, 10'h030, "busy ignore")
    // A stray opcode would leave the sequencer waiting for data; byte 00 must read as unknown
    prog_byte = '{valid: 1'b1, value: 8'h00};
    tick();
    prog_byte = '0;
    `CHK({unk, busy}, 2'h2, "no stray start")
  endtask

  // Reset in mid-execution, then an instruction right after release
  task automatic t_reset_mid();
    set_state(8'h33, 1'b1, 1'b1);
    send(8'hF4, 8'h01);
    tick();
    rst_b = 1'b0;
    tick();
    rst_b = 1'b1;
    t_reset();
    run_op(8'hF4, 8'h33, 8'h01, 1'b1, 1'b0, 11);
  endtask

  // Verdict and end of run
  task automatic test_done();
    if (errors == 0 && check_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // Watchdog
  initial begin
    #200000;
    errors++;
    test_done();
  end

  // Main sequence
  initial begin
    errors = 0;
    check_count = 0;
    rst_b = 1'b0;
    prog_byte = '0;
    load = '0;
    repeat (4) @(posedge ref_clk);
    #1;
    rst_b = 1'b1;
    t_reset();
    t_bcd();
    t_bin();
    t_cmp();
    t_unknown();
    t_busy();
    t_reset_mid();
    test_done();
  end

endmodule // test_immediate_arith_alu

`default_nettype wire
